// ===== include/bcr_consts.vh
// Purpose: Constants for the branch, call and return sequencer.
// Assumes: 10-bit instruction words, one 40 MHz core clock.
// Notes: Operation
// Operation
// - In-page branch: low seven bits replace PC low part, page kept.
// - Far branch, two words: page from both words, low from second.
// - Indirect far branch: page from word, low is D[2:0] then A[3:0].
// - Page-two call: push PC, page becomes 2, low from word.
// - Far call, two words: push PC, then load page and low.
// - Indirect far call: push PC, page from word, low from D and A.
// - Interrupt return, one cycle: pop PC, index minus one.
// - Interrupt return restores pointer, carry, skip, no-op, A and B.
// - Plain return, two cycles: pop PC, index minus one.
// - Skip return: pop like plain return, then skip next instruction.
// - Gate-clear instruction clears the global interrupt gate.
// - Gate-set instruction sets the global interrupt gate.
// - Ext0 test: skip next when flag set, then clear flag.
// - Ext1 test: skip next when flag set, then clear flag.
// - Page field six bits wide, covering pages zero to 63.
// - Chained immediate loads: only first runs; no-op status is context.
`ifndef BCR_CONSTS_VH
`define BCR_CONSTS_VH

`define BCR_PAGE_W 6
`define BCR_LOW_W 7
`define BCR_PC_W 13
`define BCR_SP_W 3
`define BCR_STACK_DEPTH 8
`define BCR_SP_RST 3'h7
`define BCR_CALL_PAGE 6'h02
`define BCR_X_W 2
`define BCR_Y_W 4
`define BCR_Z_W 2

// Opcode patterns
`define BCR_OP_B_TOP 3'h3
`define BCR_OP_BM_TOP 3'h2
`define BCR_OP_BL_TOP 5'h07
`define BCR_OP_BML_TOP 5'h06
`define BCR_OP_BLA 10'h010
`define BCR_OP_CALL_FAR_INDIRECT 10'h030
`define BCR_OP_RTI 10'h046
`define BCR_OP_RT 10'h044
`define BCR_OP_RTS 10'h045
`define BCR_OP_DI 10'h004
`define BCR_OP_EI 10'h005
`define BCR_OP_TEST_EXT0_REQUEST 10'h038
`define BCR_OP_TEST_EXT1_REQUEST 10'h039

// Register offsets (byte addresses)
`define BCR_REG_CTRL 8'h00
`define BCR_REG_STATUS 8'h04
`define BCR_REG_IRQ_STAT 8'h08
`define BCR_REG_IRQ_MASK 8'h0c
`define BCR_CTRL_RUN_BIT 0
`define BCR_CTRL_RST 1'h1
`define BCR_ST_SP_LSB 16
`define BCR_ST_GATE_BIT 20
`define BCR_ST_EXT0_BIT 21
`define BCR_ST_EXT1_BIT 22
`define BCR_ST_SKIP_BIT 23
`define BCR_ST_NOP_BIT 24
`define BCR_EV_W 4
`define BCR_EV_EXT0 0
`define BCR_EV_EXT1 1
`define BCR_EV_IRQ_TAKEN 2
`define BCR_EV_RETURN 3
`define BCR_MASK_RST 4'h0

`endif

// ===== core/bcr_sequencer.v
// Purpose: Executes branch, call, return and interrupt-gate instructions.
// Assumes: Program memory answers in the same cycle as o_pc; all inputs
//          come from logic on i_clk_sys.
// Notes: Other words are flagged on o_other_exec for the remaining units.
`include "bcr_consts.vh"

module bcr_sequencer (
    input wire i_clk_sys,
    input wire i_sys_rst,
    input wire [9:0] i_rom_data,
    input wire [2:0] i_reg_d_bits,
    input wire [3:0] i_acc,
    input wire i_acc_load_word,
    input wire i_skip_req,
    input wire i_irq_req,
    input wire [`BCR_PC_W-1:0] i_irq_vector,
    input wire i_ext0_event,
    input wire i_ext1_event,
    input wire [`BCR_X_W-1:0] i_ctx_x,
    input wire [`BCR_Y_W-1:0] i_ctx_y,
    input wire [`BCR_Z_W-1:0] i_ctx_z,
    input wire i_ctx_carry,
    input wire [3:0] i_ctx_b,
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire i_wb_we,
    input wire [7:0] i_wb_adr,
    input wire [3:0] i_wb_sel,
    input wire [31:0] i_wb_dat,
    output wire [`BCR_PC_W-1:0] o_pc,
    output wire o_other_exec,
    output wire o_acc_load_exec,
    output wire o_irq_ack,
    output wire o_global_irq_gate,
    output wire o_ctx_restore,
    output reg [`BCR_X_W-1:0] o_ctx_x,
    output reg [`BCR_Y_W-1:0] o_ctx_y,
    output reg [`BCR_Z_W-1:0] o_ctx_z,
    output reg o_ctx_carry,
    output reg [3:0] o_ctx_a,
    output reg [3:0] o_ctx_b,
    output reg [31:0] o_wb_dat,
    output wire o_wb_ack,
    output wire o_irq
);

////////////////////////////////////////////////////////////////////////////
localparam [2:0] ST_EXEC = 3'h1;
localparam [2:0] ST_WORD2 = 3'h2;
localparam [2:0] ST_IDLE = 3'h4;

localparam [3:0] K_NONE = 4'h0;
localparam [3:0] K_B = 4'h1;
localparam [3:0] K_BL = 4'h2;
localparam [3:0] K_BLA = 4'h3;
localparam [3:0] K_BM = 4'h4;
localparam [3:0] K_BML = 4'h5;
localparam [3:0] K_CALL_FAR_INDIRECT = 4'h6;
localparam [3:0] K_RTI = 4'h7;
localparam [3:0] K_RT = 4'h8;
localparam [3:0] K_RTS = 4'h9;
localparam [3:0] K_DI = 4'ha;
localparam [3:0] K_EI = 4'hb;
localparam [3:0] K_TEST_EXT0_REQUEST = 4'hc;
localparam [3:0] K_TEST_EXT1_REQUEST = 4'hd;

function [3:0] fn_kind;
    input [9:0] w;
    begin
        if (w[9:7] == `BCR_OP_B_TOP)
            fn_kind = K_B;
        else if (w[9:7] == `BCR_OP_BM_TOP)
            fn_kind = K_BM;
        else if (w[9:5] == `BCR_OP_BL_TOP)
            fn_kind = K_BL;
        else if (w[9:5] == `BCR_OP_BML_TOP)
            fn_kind = K_BML;
        else begin
            case (w)
                `BCR_OP_BLA: fn_kind = K_BLA;
                `BCR_OP_CALL_FAR_INDIRECT: fn_kind = K_CALL_FAR_INDIRECT;
                `BCR_OP_RTI: fn_kind = K_RTI;
                `BCR_OP_RT: fn_kind = K_RT;
                `BCR_OP_RTS: fn_kind = K_RTS;
                `BCR_OP_DI: fn_kind = K_DI;
                `BCR_OP_EI: fn_kind = K_EI;
                `BCR_OP_TEST_EXT0_REQUEST: fn_kind = K_TEST_EXT0_REQUEST;
                `BCR_OP_TEST_EXT1_REQUEST: fn_kind = K_TEST_EXT1_REQUEST;
                default: fn_kind = K_NONE;
            endcase
        end
    end
endfunction

function fn_two_word;
    input [3:0] k;
    begin
        fn_two_word = (k == K_BL) || (k == K_BLA) || (k == K_BML) ||
            (k == K_CALL_FAR_INDIRECT);
    end
endfunction

////////////////////////////////////////////////////////////////////////////
reg [2:0] state_r;
reg [9:0] word1_r;
reg skip2_r;
reg skip_r;
reg lanop_r;
reg [`BCR_PAGE_W-1:0] page_r;
reg [`BCR_LOW_W-1:0] low_r;
reg [`BCR_SP_W-1:0] sp_r;
reg [`BCR_PC_W-1:0] stack_r [0:`BCR_STACK_DEPTH-1];
reg gate_r;
reg ext0_r;
reg ext1_r;
reg sv_skip_r;
reg sv_lanop_r;
reg restore_r;
reg run_r;
reg [`BCR_EV_W-1:0] ev_stat_r;
reg [`BCR_EV_W-1:0] ev_mask_r;
reg ack_r;

wire [3:0] kind = fn_kind(i_rom_data);
wire [3:0] kind1 = fn_kind(word1_r);
wire in_exec = run_r && (state_r == ST_EXEC);
wire in_word2 = run_r && (state_r == ST_WORD2);
wire take_irq = in_exec && gate_r && i_irq_req && !skip_r;
wire la_chain = i_acc_load_word && lanop_r;
wire do_exec = in_exec && !take_irq && !skip_r && !la_chain;
wire do_word2 = in_word2 && !skip2_r;
wire [`BCR_SP_W-1:0] sp_up = sp_r + 1'b1;
wire [`BCR_SP_W-1:0] sp_dn = sp_r - 1'b1;
wire [`BCR_LOW_W-1:0] low_inc = low_r + 1'b1;
wire [`BCR_PC_W-1:0] ret_addr = {page_r, low_inc};
wire [`BCR_PC_W-1:0] top_slot = stack_r[sp_r];
wire [`BCR_LOW_W-1:0] low_ind = {i_reg_d_bits, i_acc};
wire ret_any = do_exec &&
    (kind == K_RTI || kind == K_RT || kind == K_RTS);
wire clr_ext0 = do_exec && kind == K_TEST_EXT0_REQUEST && ext0_r;
wire clr_ext1 = do_exec && kind == K_TEST_EXT1_REQUEST && ext1_r;
wire push_one = do_exec && kind == K_BM;
wire push_two = do_word2 && (kind1 == K_BML || kind1 == K_CALL_FAR_INDIRECT);

assign o_pc = {page_r, low_r};
assign o_other_exec = do_exec && kind == K_NONE;
assign o_acc_load_exec = do_exec && kind == K_NONE && i_acc_load_word;
assign o_irq_ack = take_irq;
assign o_global_irq_gate = gate_r;
assign o_ctx_restore = restore_r;

////////////////////////////////////////////////////////////////////////////
// Program flow
always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
        state_r <= ST_EXEC;
        word1_r <= 10'h000;
        skip2_r <= 1'b0;
        skip_r <= 1'b0;
        lanop_r <= 1'b0;
        page_r <= {`BCR_PAGE_W{1'b0}};
        low_r <= {`BCR_LOW_W{1'b0}};
        sp_r <= `BCR_SP_RST;
        gate_r <= 1'b0;
        sv_skip_r <= 1'b0;
        sv_lanop_r <= 1'b0;
        restore_r <= 1'b0;
    end else begin
        restore_r <= 1'b0;
        case (state_r)
            ST_EXEC: begin
                if (!run_r) begin
                    state_r <= ST_EXEC;
                end else if (take_irq) begin
                    // Vector taken in place of this word; it reruns later
                    sp_r <= sp_up;
                    page_r <= i_irq_vector[`BCR_PC_W-1:`BCR_LOW_W];
                    low_r <= i_irq_vector[`BCR_LOW_W-1:0];
                    gate_r <= 1'b0;
                    sv_skip_r <= skip_r;
                    sv_lanop_r <= lanop_r;
                end else if (skip_r || la_chain) begin
                    skip_r <= 1'b0;
                    lanop_r <= la_chain;
                    word1_r <= i_rom_data;
                    skip2_r <= 1'b1;
                    low_r <= low_inc;
                    if (fn_two_word(kind))
                        state_r <= ST_WORD2;
                end else begin
                    word1_r <= i_rom_data;
                    skip2_r <= 1'b0;
                    lanop_r <= i_acc_load_word && kind == K_NONE;
                    low_r <= low_inc;
                    case (kind)
                        K_B: low_r <= i_rom_data[6:0];
                        K_BL, K_BLA, K_BML, K_CALL_FAR_INDIRECT:
                            state_r <= ST_WORD2;
                        K_BM: begin
                            sp_r <= sp_up;
                            page_r <= `BCR_CALL_PAGE;
                            low_r <= i_rom_data[6:0];
                        end
                        K_RTI: begin
                            page_r <= top_slot[`BCR_PC_W-1:`BCR_LOW_W];
                            low_r <= top_slot[`BCR_LOW_W-1:0];
                            sp_r <= sp_dn;
                            skip_r <= sv_skip_r;
                            lanop_r <= sv_lanop_r;
                            restore_r <= 1'b1;
                        end
                        K_RT, K_RTS: begin
                            page_r <= top_slot[`BCR_PC_W-1:`BCR_LOW_W];
                            low_r <= top_slot[`BCR_LOW_W-1:0];
                            sp_r <= sp_dn;
                            skip_r <= kind == K_RTS;
                            state_r <= ST_IDLE;
                        end
                        K_DI: gate_r <= 1'b0;
                        K_EI: gate_r <= 1'b1;
                        K_TEST_EXT0_REQUEST: skip_r <= ext0_r;
                        K_TEST_EXT1_REQUEST: skip_r <= ext1_r;
                        default: skip_r <= i_skip_req;
                    endcase
                end
            end
            ST_WORD2: begin
                if (run_r) begin
                    state_r <= ST_EXEC;
                    low_r <= low_inc;
                    if (!skip2_r) begin
                        case (kind1)
                            K_BL, K_BML: begin
                                page_r <= {i_rom_data[7], word1_r[4:0]};
                                low_r <= i_rom_data[6:0];
                            end
                            K_BLA, K_CALL_FAR_INDIRECT: begin
                                page_r <= {i_rom_data[7:6],
                                    i_rom_data[3:0]};
                                low_r <= low_ind;
                            end
                            default: low_r <= low_inc;
                        endcase
                        if (push_two)
                            sp_r <= sp_up;
                    end
                end
            end
            ST_IDLE: begin
                // Second cycle of a return; the fetched word is discarded
                if (run_r)
                    state_r <= ST_EXEC;
            end
            default: state_r <= ST_EXEC;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// Return-address stack; slot written is the one the index moves to
always @(posedge i_clk_sys) begin
    if (take_irq)
        stack_r[sp_up] <= o_pc;
    else if (push_one)
        stack_r[sp_up] <= ret_addr;
    else if (push_two)
        stack_r[sp_up] <= ret_addr;
end

////////////////////////////////////////////////////////////////////////////
// Saved context for the interrupt return
always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
        o_ctx_x <= {`BCR_X_W{1'b0}};
        o_ctx_y <= {`BCR_Y_W{1'b0}};
        o_ctx_z <= {`BCR_Z_W{1'b0}};
        o_ctx_carry <= 1'b0;
        o_ctx_a <= 4'h0;
        o_ctx_b <= 4'h0;
    end else if (take_irq) begin
        o_ctx_x <= i_ctx_x;
        o_ctx_y <= i_ctx_y;
        o_ctx_z <= i_ctx_z;
        o_ctx_carry <= i_ctx_carry;
        o_ctx_a <= i_acc;
        o_ctx_b <= i_ctx_b;
    end
end

////////////////////////////////////////////////////////////////////////////
// External request flags; a new event beats the test's clear
always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
        ext0_r <= 1'b0;
        ext1_r <= 1'b0;
    end else begin
        ext0_r <= i_ext0_event | (ext0_r & ~clr_ext0);
        ext1_r <= i_ext1_event | (ext1_r & ~clr_ext1);
    end
end

////////////////////////////////////////////////////////////////////////////
// Wishbone slave, one wait state
wire wb_req = i_wb_cyc && i_wb_stb && !ack_r;
// Writes land at the ack edge, while the master still holds the request
wire wb_wr0 = i_wb_cyc && i_wb_stb && ack_r && i_wb_we && i_wb_sel[0];
wire [`BCR_EV_W-1:0] ev_now;
wire [31:0] status_word;

assign ev_now[`BCR_EV_EXT0] = i_ext0_event;
assign ev_now[`BCR_EV_EXT1] = i_ext1_event;
assign ev_now[`BCR_EV_IRQ_TAKEN] = take_irq;
assign ev_now[`BCR_EV_RETURN] = ret_any;
assign o_wb_ack = ack_r;
assign o_irq = |(ev_stat_r & ev_mask_r);
assign status_word = {7'h00, lanop_r, skip_r, ext1_r, ext0_r, gate_r,
    1'b0, sp_r, 3'h0, o_pc};

always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
        ack_r <= 1'b0;
        o_wb_dat <= 32'h00000000;
        run_r <= `BCR_CTRL_RST;
        ev_stat_r <= {`BCR_EV_W{1'b0}};
        ev_mask_r <= `BCR_MASK_RST;
    end else begin
        ack_r <= wb_req;
        // Set wins over a simultaneous write-one clear
        if (wb_wr0 && i_wb_adr == `BCR_REG_IRQ_STAT)
            ev_stat_r <= ev_now | (ev_stat_r & ~i_wb_dat[`BCR_EV_W-1:0]);
        else
            ev_stat_r <= ev_now | ev_stat_r;
        if (wb_wr0 && i_wb_adr == `BCR_REG_IRQ_MASK)
            ev_mask_r <= i_wb_dat[`BCR_EV_W-1:0];
        if (wb_wr0 && i_wb_adr == `BCR_REG_CTRL)
            run_r <= i_wb_dat[`BCR_CTRL_RUN_BIT];
        if (wb_req && !i_wb_we) begin
            case (i_wb_adr)
                `BCR_REG_CTRL: o_wb_dat <= {31'h00000000, run_r};
                `BCR_REG_STATUS: o_wb_dat <= status_word;
                `BCR_REG_IRQ_STAT: o_wb_dat <= {28'h0000000, ev_stat_r};
                `BCR_REG_IRQ_MASK: o_wb_dat <= {28'h0000000, ev_mask_r};
                default: o_wb_dat <= 32'h00000000;
            endcase
        end
    end
end

endmodule

// ===== tb/bcr_properties.sv
// Purpose: Port-level properties of the flow-control sequencer.
// Assumes: One clock, synchronous active-high reset.
// Notes: Skip state is internal, so page checks allow the skipped case.
`include "bcr_consts.vh"
module bcr_properties (
    input wire i_clk_sys,
    input wire i_sys_rst,
    input wire [9:0] i_rom_data,
    input wire i_acc_load_word,
    input wire [`BCR_PC_W-1:0] i_irq_vector,
    input wire i_wb_cyc,
    input wire i_wb_stb,
    input wire [`BCR_PC_W-1:0] o_pc,
    input wire o_acc_load_exec,
    input wire o_irq_ack,
    input wire o_global_irq_gate,
    input wire o_ctx_restore,
    input wire o_wb_ack
);
    timeunit 1ns;
    timeprecision 100ps;
    wire [5:0] pg = o_pc[12:7];
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
////////////////////////////////////////////////////////////
    ack_next_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("bus ack late");
    ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("bus ack longer than one cycle");
    ack_cause_a: assert property ($rose(o_wb_ack) |-> $past(i_wb_stb))
        else $error("bus ack without request");
    page_kept_a: assert property (i_rom_data[9:7] == `BCR_OP_B_TOP && !o_irq_ack
        |=> pg == $past(pg)) else $error("in-page branch left page");
    call_page_a: assert property (i_rom_data[9:7] == `BCR_OP_BM_TOP && !o_irq_ack
        |=> pg == `BCR_CALL_PAGE || pg == $past(pg))
        else $error("page-two call went elsewhere");
    gate_rise_a: assert property ($rose(o_global_irq_gate)
        |-> $past(i_rom_data) == `BCR_OP_EI) else $error("gate set wrongly");
    gate_fall_a: assert property ($fell(o_global_irq_gate)
        |-> $past(i_rom_data) == `BCR_OP_DI || $past(o_irq_ack))
        else $error("gate cleared wrongly");
    ack_gated_a: assert property (o_irq_ack |-> o_global_irq_gate)
        else $error("interrupt taken with gate closed");
    vector_load_a: assert property (o_irq_ack
        |=> o_pc == $past(i_irq_vector) && !o_global_irq_gate)
        else $error("vector not loaded on accept");
    load_word_a: assert property (o_acc_load_exec |-> i_acc_load_word)
        else $error("load executed on other word");
    load_chain_a: assert property (o_acc_load_exec ##1 i_acc_load_word
        |-> !o_acc_load_exec) else $error("chained load executed");
    restore_cause_a: assert property (o_ctx_restore
        |-> $past(i_rom_data) == `BCR_OP_RTI) else $error("restore w/o return");
endmodule
bind bcr_sequencer bcr_properties i_props (.i_clk_sys, .i_sys_rst,
    .i_rom_data, .i_acc_load_word, .i_irq_vector, .i_wb_cyc, .i_wb_stb,
    .o_pc, .o_acc_load_exec, .o_irq_ack, .o_global_irq_gate,
    .o_ctx_restore, .o_wb_ack);

// ===== tb/bcr_rom_model.sv
// Purpose: Program memory holding the test program.
// Assumes: Combinational read, same cycle as the address.
// Notes: Immediate accumulator loads are the words 0x070 to 0x07f.
`include "bcr_consts.vh"
module bcr_rom_model (
    input wire logic [`BCR_PC_W-1:0] i_addr,
    output logic [9:0] o_word,
    output logic o_acc_load
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [9:0] mem [0:8191];
    logic [22:0] prog [25] = '{
        {13'h000, 10'h005}, {13'h001, 10'h190}, {13'h010, 10'h0c5},
        {13'h011, 10'h220}, {13'h2a0, 10'h105}, {13'h105, 10'h045},
        {13'h2a1, 10'h004}, {13'h2a2, 10'h044}, {13'h012, 10'h038},
        {13'h013, 10'h0e7}, {13'h014, 10'h27f}, {13'h015, 10'h039},
        {13'h016, 10'h010}, {13'h017, 10'h203}, {13'h1da, 10'h030},
        {13'h1db, 10'h281}, {13'h10da, 10'h0ff}, {13'h10db, 10'h2ff},
        {13'h1fff, 10'h004}, {13'h1f80, 10'h044}, {13'h1dc, 10'h071},
        {13'h1dd, 10'h072}, {13'h1de, 10'h005}, {13'h1df, 10'h1df},
        {13'h200, 10'h046}};
    assign o_word = mem[i_addr];
    assign o_acc_load = (o_word[9:4] == 6'h07);
    initial begin
        // Filler words belong to other units and simply advance the PC
        for (int i = 0; i < 8192; i++) mem[i] = 10'h000;
        foreach (prog[i]) mem[prog[i][22:10]] = prog[i][9:0];
    end
endmodule

// ===== tb/tb_branch_call_return_sequencer.sv
// Purpose: Self-checking bench for the flow-control sequencer.
// Assumes: PC trace below is worked out by hand from the ROM program.
// Notes: Register checks run while the program spins in its last loop.
`include "bcr_consts.vh"
module tb_branch_call_return_sequencer;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_ext0_event = 1'b0;
    logic i_ext1_event = 1'b0;
    logic i_irq_req = 1'b0;
    logic i_skip_req = 1'b0;
    logic i_wb_cyc = 1'b0;
    logic i_wb_stb = 1'b0;
    logic i_wb_we = 1'b0;
    logic [7:0] i_wb_adr = 8'h00;
    logic [3:0] i_wb_sel = 4'hf;
    logic [31:0] i_wb_dat = 32'h0;
    logic [2:0] i_reg_d_bits = 3'h5;
    logic [3:0] i_acc = 4'ha;
    logic [1:0] i_ctx_x = 2'h2;
    logic [3:0] i_ctx_y = 4'h9;
    logic [1:0] i_ctx_z = 2'h1;
    logic i_ctx_carry = 1'b1;
    logic [3:0] i_ctx_b = 4'h6;
    logic [12:0] i_irq_vector = 13'h200;
    wire [9:0] i_rom_data;
    wire i_acc_load_word;
    wire [12:0] o_pc;
    wire [1:0] o_ctx_x, o_ctx_z;
    wire [3:0] o_ctx_y, o_ctx_a, o_ctx_b;
    wire [31:0] o_wb_dat;
    wire o_acc_load_exec, o_irq_ack, o_global_irq_gate, o_ctx_restore;
    wire o_ctx_carry, o_wb_ack, o_irq, o_other_exec;
    logic [31:0] rd;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [12:0] ep [1:29] = '{13'h001, 13'h010, 13'h011, 13'h2a0, 13'h105,
        13'h2a1, 13'h2a1, 13'h2a2, 13'h012, 13'h012, 13'h013, 13'h014,
        13'h015, 13'h016, 13'h017, 13'h1da, 13'h1db, 13'h10da, 13'h10db,
        13'h1fff, 13'h1f80, 13'h1dc, 13'h1dc, 13'h1dd, 13'h1de, 13'h1df,
        13'h200, 13'h1df, 13'h1df};
    bcr_sequencer i_dut (.*);
    bcr_rom_model i_rom (.i_addr(o_pc), .o_word(i_rom_data),
        .o_acc_load(i_acc_load_word));
    always #12.5 i_clk_sys = ~i_clk_sys;
////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task summarize();
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Classic single cycle; the wait is bounded, not assumed
    task automatic wb(input logic we, input logic [7:0] adr,
            input logic [31:0] wd, output logic [31:0] rdat);
        int k;
        k = 0;
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= we;
        i_wb_adr <= adr;
        i_wb_dat <= wd;
        do begin
            @(posedge i_clk_sys);
            k++;
        end while (o_wb_ack !== 1'b1 && k < 20);
        if (k == 20) n_mismatch++;
        rdat = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
        @(posedge i_clk_sys);
    endtask
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 500) begin
            n_mismatch++;
            summarize();
        end
    end
////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        for (int n = 1; n <= 29; n++) begin
            @(posedge i_clk_sys);
            i_ext0_event <= (n == 1);
            i_ext1_event <= (n == 15);
            i_irq_req <= (n == 26);
            // Live context moves after the accept; saved copy must not
            if (n == 27) i_ctx_y <= 4'h3;
            if (n == 27) i_acc <= 4'h0;
            #1;
            if (n < 6) chk("pc", o_pc, ep[n]);
            else if (n < 11) chk("pc", o_pc, ep[n]);
            else if (n < 16) chk("pc", o_pc, ep[n]);
            else if (n < 19) chk("pc", o_pc, ep[n]);
            else if (n < 22) chk("pc", o_pc, ep[n]);
            else chk("pc", o_pc, ep[n]);
            if (n == 26) chk("irq ack", o_irq_ack, 1'b1);
            if (n == 28) chk("ctx", {o_ctx_restore, o_ctx_x, o_ctx_y, o_ctx_z,
                o_ctx_carry, o_ctx_a, o_ctx_b}, 32'h34ba6);
            if (n == 24) chk("chain idle", {o_other_exec, o_acc_load_exec},
                2'h0);
        end
        @(posedge i_clk_sys);
        wb(1'b0, `BCR_REG_STATUS, 32'h0, rd);
        chk("status", rd, 32'h004701df);
        wb(1'b0, `BCR_REG_IRQ_STAT, 32'h0, rd);
        chk("events", rd, 32'hf);
        wb(1'b1, `BCR_REG_IRQ_MASK, 32'h4, rd);
        chk("irq on", o_irq, 1'b1);
        wb(1'b1, `BCR_REG_IRQ_STAT, 32'h4, rd);
        chk("irq off", o_irq, 1'b0);
        wb(1'b0, `BCR_REG_IRQ_STAT, 32'h0, rd);
        chk("events left", rd, 32'hb);
        wb(1'b0, `BCR_REG_IRQ_MASK, 32'h0, rd);
        chk("mask", rd, 32'h4);
        wb(1'b1, 8'h10, 32'hffffffff, rd);
        wb(1'b0, 8'h10, 32'h0, rd);
        chk("unmapped", rd, 32'h0);
        wb(1'b0, `BCR_REG_CTRL, 32'h0, rd);
        chk("ctrl", rd, 32'h1);
        summarize();
    end
endmodule
